// File: dv/dcs_cfg_host.sv
// configuration requester model standing in for software behind the root complex
`timescale 1ns/10ps
module dcs_cfg_host (
  // clock
  input  wire logic                           clk_i,
  // request lines
  output logic      [dcs_pkg::CFG_ADDR_W-1:0] addr_o,
  output logic                                rd_o,
  output logic                                wr_o,
  output logic      [dcs_pkg::CFG_BE_W-1:0]   be_o,
  output logic      [dcs_pkg::CFG_DATA_W-1:0] wdata_o,
  // answer lines
  input  wire logic                           ack_i,
  input  wire logic [dcs_pkg::CFG_DATA_W-1:0] rdata_i
);
  import dcs_pkg::*;

  initial begin
    addr_o  = '0;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    be_o    = '0;
    wdata_o = '0;
  end

  // one access: strobe for a single edge, answer sampled once the ack edge has settled
  task automatic access(input logic wr, input logic [CFG_ADDR_W-1:0] addr, input logic [CFG_BE_W-1:0] be,
                        input logic [CFG_DATA_W-1:0] wdata, output logic [CFG_DATA_W-1:0] rdata, output logic ok);
    @(posedge clk_i);
    rd_o    <= !wr;
    wr_o    <= wr;
    addr_o  <= addr;
    be_o    <= be;
    wdata_o <= wdata;
    @(posedge clk_i);
    rd_o    <= 1'b0;
    wr_o    <= 1'b0;
    // released address and data lines must not keep showing the old request; be_o keeps its value
    addr_o  <= ~addr;
    wdata_o <= ~wdata;
    #1;
    ok    = (ack_i === 1'b1);
    rdata = rdata_i;
  endtask : access
endmodule : dcs_cfg_host

// File: dv/pcie_device_control_status_tb.sv
// self-checking bench for the device control and status word
`timescale 1ns/10ps
module pcie_device_control_status_tb;
  import dcs_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic [31:0] img;
  } dcs_row_s;
  localparam dcs_row_s ROWS [7] = '{
    '{12'h0c8, 4'hf, 32'hffff_ffff, 32'h0000_f4ef, 32'h0000_f4ef},
    '{12'h0c8, 4'hf, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
    '{12'h0c8, 4'h1, 32'h1234_5678, 32'h0000_0068, 32'h0000_0068},
    '{12'h0c8, 4'h2, 32'h0000_5000, 32'h0000_5068, 32'h0000_5068},
    '{12'h0c8, 4'h2, 32'h0000_a5aa, 32'h0000_a468, 32'h0000_a468},
    '{12'h0cc, 4'hf, 32'hffff_ffff, 32'h0000_0000, 32'h0000_a468},
    '{12'h0cb, 4'h0, 32'hffff_ffff, 32'h0000_a468, 32'h0000_a468}};
  localparam logic [1:0] NP_SEQ [7] = '{2'b10, 2'b10, 2'b01, 2'b11, 2'b01, 2'b01, 2'b10};
  localparam logic       NP_EXP [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  logic        clk, rst, rd, wr, ack, serr, np_issue, np_done, aux_det, ds_req, ds_nrdy;
  logic        msg_fatal, msg_nf, msg_cor, np_pend, aux_use, retry, no_snoop, relaxed;
  logic [11:0] addr;
  logic [3:0]  be, det;
  logic [31:0] wdata, rdata, rword;
  logic [2:0]  code;
  dcs_bytes_t  rd_lim, pay;
  int          n_mismatch, checks_done, cycles;

  dcs_device_ctl_status u_dut (.CLK_I(clk), .RST_I(rst), .CFG_ADDR_I(addr), .CFG_RD_I(rd), .CFG_WR_I(wr),
    .CFG_BE_I(be), .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_ACK_O(ack), .UNSUP_DET_I(det[FLG_UNSUP]),
    .FATAL_DET_I(det[FLG_FATAL]), .NONFATAL_DET_I(det[FLG_NONFATAL]), .COR_DET_I(det[FLG_COR]),
    .SERR_ALLOW_I(serr), .MSG_FATAL_O(msg_fatal), .MSG_NONFATAL_O(msg_nf), .MSG_COR_O(msg_cor),
    .NP_ISSUE_I(np_issue), .NP_DONE_I(np_done), .NP_PENDING_O(np_pend), .AUX_DETECT_I(aux_det),
    .AUX_USE_ALLOW_O(aux_use), .DS_CFG_REQ_I(ds_req), .DS_NOT_READY_I(ds_nrdy),
    .CONFIG_RETRY_STATUS_O(retry), .READ_LIMIT_BYTES_O(rd_lim), .PAYLOAD_BYTES_O(pay),
    .NO_SNOOP_ALLOW_O(no_snoop), .RELAXED_ORDER_ALLOW_O(relaxed));
  dcs_cfg_host u_host (.clk_i(clk), .addr_o(addr), .rd_o(rd), .wr_o(wr), .be_o(be), .wdata_o(wdata),
    .ack_i(ack), .rdata_i(rdata));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrreg(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] dummy;
    logic        ok;
    u_host.access(1'b1, a, b, d, dummy, ok);
    chk("write ack", 32'h1, 32'(ok));
  endtask : wrreg

  task automatic rdreg(input logic [11:0] a);
    logic ok;
    u_host.access(1'b0, a, 4'h0, 32'h0, rword, ok);
    chk("read ack", 32'h1, 32'(ok));
  endtask : rdreg

  // message vector {fatal, nonfatal, cor} for flag i; pass 1 opens the alternative gate, pass 2 the enables
  function automatic logic [2:0] exp_msg(input int i, input int p);
    logic en;
    logic sr;
    en = (p == 2);
    sr = (p == 1);
    case (i)
      FLG_COR:      exp_msg = {2'b00, en};
      FLG_NONFATAL: exp_msg = {1'b0, en | sr, 1'b0};
      FLG_FATAL:    exp_msg = {en | sr, 2'b00};
      default:      exp_msg = {1'b0, en, 1'b0};
    endcase
  endfunction : exp_msg

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    det = '0;
    serr = 1'b0;
    np_issue = 1'b0;
    np_done = 1'b0;
    aux_det = 1'b0;
    ds_req = 1'b1;
    ds_nrdy = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("reset limit", 32'd512, 32'(rd_lim));
    rdreg(12'h0c8);
    chk("reset word", 32'h0000_2000, rword);
    foreach (ROWS[i]) begin
      wrreg(ROWS[i].addr, ROWS[i].be, ROWS[i].wdata);
      rdreg(ROWS[i].addr);
      chk("word", ROWS[i].exp, rword);
      code = ROWS[i].img[14:12];
      chk("read limit", (code > 3'h5) ? 32'h80 : (32'h80 << code), 32'(rd_lim));
      chk("aux use", 32'(ROWS[i].img[10]), 32'(aux_use));
      chk("retry", 32'(ROWS[i].img[15]), 32'(retry));
      chk("payload", 32'h80, 32'(pay));
      chk("fixed attrs", 32'h0, {30'h0, no_snoop, relaxed});
    end
    ds_nrdy <= 1'b0;
    #1;
    chk("retry ready", 32'h0, 32'(retry));
    ds_nrdy <= 1'b1;
    ds_req <= 1'b0;
    #1;
    chk("retry no request", 32'h0, 32'(retry));
    wrreg(12'h0c8, 4'h1, 32'h0);
    for (int p = 0; p < 3; p++) begin
      serr <= (p == 1);
      if (p == 2) begin
        wrreg(12'h0c8, 4'h1, 32'h0000_000f);
      end
      for (int i = 0; i < NUM_FLAGS; i++) begin
        @(posedge clk);
        det <= 4'(1 << i);
        @(posedge clk);
        det <= '0;
        #1;
        chk("message", 32'(exp_msg(i, p)), {29'h0, msg_fatal, msg_nf, msg_cor});
        rdreg(12'h0c8);
        chk("flag set", 32'(1 << i), 32'(rword[19:16]));
        wrreg(12'h0c8, 4'h4, 32'h0);
        rdreg(12'h0c8);
        chk("flag kept", 32'(1 << i), 32'(rword[19:16]));
        wrreg(12'h0c8, 4'h4, 32'(1 << (FLAG_LSB + i)));
        rdreg(12'h0c8);
        chk("flag cleared", 32'h0, 32'(rword[19:16]));
      end
    end
    // a detection in the same edge as its clearing write must survive
    fork
      wrreg(12'h0c8, 4'h4, 32'(1 << (FLAG_LSB + FLG_FATAL)));
      begin
        @(posedge clk);
        det <= 4'(1 << FLG_FATAL);
        @(posedge clk);
        det <= '0;
      end
    join
    rdreg(12'h0c8);
    chk("set beats clear", 32'h1, 32'(rword[18]));
    foreach (NP_SEQ[i]) begin
      @(posedge clk);
      np_issue <= NP_SEQ[i][1];
      np_done <= NP_SEQ[i][0];
      @(posedge clk);
      np_issue <= 1'b0;
      np_done <= 1'b0;
      #1;
      chk("pending", 32'(NP_EXP[i]), 32'(np_pend));
    end
    rdreg(12'h0c8);
    chk("pending bit", 32'h1, 32'(rword[21]));
    aux_det <= 1'b1;
    repeat (2) @(posedge clk);
    rdreg(12'h0c8);
    chk("aux seen", 32'h1, 32'(rword[20]));
    aux_det <= 1'b0;
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk("limit in reset", 32'd512, 32'(rd_lim));
    chk("pending in reset", 32'h0, 32'(np_pend));
    rst <= 1'b0;
    rdreg(12'h0c8);
    chk("word after reset", 32'h0000_2000, rword);
    end_sim();
  end
endmodule : pcie_device_control_status_tb

// File: hdl/dcs_device_ctl_status.sv
// device control and status word of the bridge express capability
`timescale 1ns/10ps
// Operation
// - Word lives at config offset 0x0c8, resets to 0x0000_2000.
// - Bits 31 to 22 always read zero.
// - Bit 21 high while any issued non-posted request awaits completion.
// - Bit 20 reports auxiliary power detected; power is not needed.
// - Bit 19 sets on unsupported request, cleared by writing one.
// - Bit 18 sets on fatal error, cleared by writing one.
// - Bit 17 sets on non-fatal error, cleared by writing one.
// - Bit 16 sets on correctable error, cleared by writing one.
// - Bit 15 makes downstream config requests answer with retry status while downstream is not ready.
// - Field 14:12 caps own read request size; reset code 010.
// - No-snoop is never used; bit 11 reads zero.
// - Bit 10 allows extra auxiliary power draw.
// - Phantom function and wide tag enables read zero.
// - Relaxed ordering bit 4 reads zero.
// - Bit 3 enables reporting of unsupported requests.
// - Bit 2 gates fatal error messages.
// - Bit 1 gates non-fatal error messages.
// - Bit 0 gates correctable error messages.
module dcs_device_ctl_status (
  // clock and reset
  input  wire logic                         CLK_I,
  input  wire logic                         RST_I,
  // configuration access
  input  wire logic [dcs_pkg::CFG_ADDR_W-1:0] CFG_ADDR_I,
  input  wire logic                         CFG_RD_I,
  input  wire logic                         CFG_WR_I,
  input  wire logic [dcs_pkg::CFG_BE_W-1:0] CFG_BE_I,
  input  wire logic [dcs_pkg::CFG_DATA_W-1:0] CFG_WDATA_I,
  output logic      [dcs_pkg::CFG_DATA_W-1:0] CFG_RDATA_O,
  output logic                              CFG_ACK_O,
  // error detection events
  input  wire logic                         UNSUP_DET_I,
  input  wire logic                         FATAL_DET_I,
  input  wire logic                         NONFATAL_DET_I,
  input  wire logic                         COR_DET_I,
  input  wire logic                         SERR_ALLOW_I,
  // error message requests
  output logic                              MSG_FATAL_O,
  output logic                              MSG_NONFATAL_O,
  output logic                              MSG_COR_O,
  // non-posted tracking
  input  wire logic                         NP_ISSUE_I,
  input  wire logic                         NP_DONE_I,
  output logic                              NP_PENDING_O,
  // auxiliary power
  input  wire logic                         AUX_DETECT_I,
  output logic                              AUX_USE_ALLOW_O,
  // downstream configuration retry
  input  wire logic                         DS_CFG_REQ_I,
  input  wire logic                         DS_NOT_READY_I,
  output logic                              CONFIG_RETRY_STATUS_O,
  // transfer limits
  output dcs_pkg::dcs_bytes_t               READ_LIMIT_BYTES_O,
  output dcs_pkg::dcs_bytes_t               PAYLOAD_BYTES_O,
  output logic                              NO_SNOOP_ALLOW_O,
  output logic                              RELAXED_ORDER_ALLOW_O
);
  import dcs_pkg::*;

  // control fields
  logic                  retry_en_r;
  dcs_size_t             read_limit_r;
  logic                  aux_supply_use_allow_r;
  dcs_size_t             payload_limit_r;
  logic                  unsupported_req_report_r;
  logic                  fatal_report_r;
  logic                  nonfatal_report_r;
  logic                  correctable_report_r;
  // status
  logic                  aux_supply_seen_r;
  logic [NP_CNT_W-1:0]   np_cnt_r;
  logic [NP_CNT_W-1:0]   np_cnt_nxt;
  logic                  nonposted_outstanding;
  logic [CFG_DATA_W-1:0] csr_value;
  logic                  hit;
  logic                  wr_hit;
  logic                  fatal_send;
  logic                  nonfatal_send;
  logic                  cor_send;

  dcs_flag_if            flags ();

  assign hit    = (CFG_ADDR_I[CFG_ADDR_W-1:2] == DCS_OFFSET[CFG_ADDR_W-1:2]);
  assign wr_hit = CFG_WR_I && hit;

  // sticky error flags
  assign flags.detect[FLG_COR]      = COR_DET_I;
  assign flags.detect[FLG_NONFATAL] = NONFATAL_DET_I;
  assign flags.detect[FLG_FATAL]    = FATAL_DET_I;
  assign flags.detect[FLG_UNSUP]    = UNSUP_DET_I;
  // only ones in the flag byte clear anything
  assign flags.clear = (wr_hit && CFG_BE_I[2]) ? CFG_WDATA_I[FLAG_LSB +: NUM_FLAGS] : '0;

  dcs_sticky_flags u_flags (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .fl    (flags.owner)
  );

  // byte 1 control: retry, read size, aux use
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      retry_en_r             <= CTRL_BIT_RST;
      read_limit_r           <= MRRS_RST;
      aux_supply_use_allow_r <= CTRL_BIT_RST;
    end else if (wr_hit && CFG_BE_I[1]) begin
      retry_en_r             <= CFG_WDATA_I[BIT_RETRY];
      read_limit_r           <= CFG_WDATA_I[MRRS_LSB +: 3];
      aux_supply_use_allow_r <= CFG_WDATA_I[BIT_AUX_USE];
    end
  end

  // byte 0 control: payload and reporting enables
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      payload_limit_r          <= MPS_RST;
      unsupported_req_report_r <= CTRL_BIT_RST;
      fatal_report_r           <= CTRL_BIT_RST;
      nonfatal_report_r        <= CTRL_BIT_RST;
      correctable_report_r     <= CTRL_BIT_RST;
    end else if (wr_hit && CFG_BE_I[0]) begin
      payload_limit_r          <= CFG_WDATA_I[MPS_LSB +: 3];
      unsupported_req_report_r <= CFG_WDATA_I[BIT_UR_REPORT];
      fatal_report_r           <= CFG_WDATA_I[BIT_FATAL_REPORT];
      nonfatal_report_r        <= CFG_WDATA_I[BIT_NF_REPORT];
      correctable_report_r     <= CFG_WDATA_I[BIT_COR_REPORT];
    end
  end

  // aux detect is a plain level, sampled once a cycle
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aux_supply_seen_r <= 1'b0;
    end else begin
      aux_supply_seen_r <= AUX_DETECT_I;
    end
  end

  // outstanding non-posted count; saturates so a stray completion cannot wrap
  always_comb begin
    np_cnt_nxt = np_cnt_r;
    if (NP_ISSUE_I && !NP_DONE_I && (np_cnt_r != '1)) begin
      np_cnt_nxt = np_cnt_r + 1'b1;
    end else if (!NP_ISSUE_I && NP_DONE_I && (np_cnt_r != '0)) begin
      np_cnt_nxt = np_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      np_cnt_r <= '0;
    end else begin
      np_cnt_r <= np_cnt_nxt;
    end
  end

  assign nonposted_outstanding = (np_cnt_r != '0);
  assign NP_PENDING_O          = nonposted_outstanding;

  // read image; hardwired and reserved fields are constant zero
  always_comb begin
    csr_value                        = '0;
    csr_value[BIT_PENDING]           = nonposted_outstanding;
    csr_value[BIT_AUX_SEEN]          = aux_supply_seen_r;
    csr_value[FLAG_LSB +: NUM_FLAGS] = flags.flag;
    csr_value[BIT_RETRY]             = retry_en_r;
    csr_value[MRRS_LSB +: 3]         = read_limit_r;
    csr_value[BIT_NO_SNOOP]          = 1'b0;
    csr_value[BIT_AUX_USE]           = aux_supply_use_allow_r;
    csr_value[BIT_PHANTOM]           = 1'b0;
    csr_value[BIT_WIDE_TAG]          = 1'b0;
    csr_value[MPS_LSB +: 3]          = payload_limit_r;
    csr_value[BIT_RELAXED]           = 1'b0;
    csr_value[BIT_UR_REPORT]         = unsupported_req_report_r;
    csr_value[BIT_FATAL_REPORT]      = fatal_report_r;
    csr_value[BIT_NF_REPORT]         = nonfatal_report_r;
    csr_value[BIT_COR_REPORT]        = correctable_report_r;
  end

  // one-cycle answer to every access; unmapped offsets read zero
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CFG_RDATA_O <= '0;
      CFG_ACK_O   <= 1'b0;
    end else begin
      CFG_ACK_O   <= CFG_RD_I || CFG_WR_I;
      if (CFG_RD_I) begin
        CFG_RDATA_O <= hit ? csr_value : '0;
      end
    end
  end

  // unsupported requests travel as non-fatal messages when their reporting is on and the non-fatal gate is open
  assign fatal_send    = FATAL_DET_I && (fatal_report_r || SERR_ALLOW_I);
  assign nonfatal_send = (NONFATAL_DET_I || (UNSUP_DET_I && unsupported_req_report_r)) &&
                         (nonfatal_report_r || SERR_ALLOW_I);
  assign cor_send      = COR_DET_I && correctable_report_r;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MSG_FATAL_O    <= 1'b0;
      MSG_NONFATAL_O <= 1'b0;
      MSG_COR_O      <= 1'b0;
    end else begin
      MSG_FATAL_O    <= fatal_send;
      MSG_NONFATAL_O <= nonfatal_send;
      MSG_COR_O      <= cor_send;
    end
  end

  // handshake-style answer to the downstream config path
  assign CONFIG_RETRY_STATUS_O = retry_en_r && DS_CFG_REQ_I && DS_NOT_READY_I;

  assign READ_LIMIT_BYTES_O    = dcs_size_bytes(read_limit_r);
  assign PAYLOAD_BYTES_O       = BYTES_128;
  assign AUX_USE_ALLOW_O       = aux_supply_use_allow_r;
  assign NO_SNOOP_ALLOW_O      = 1'b0;
  assign RELAXED_ORDER_ALLOW_O = 1'b0;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  AST_RESET_IMAGE:
    assert property ($fell(RST_I) |-> csr_value == DCS_RESET)
    else $error("reset image wrong");
  AST_RSVD_ZERO:
    assert property (CFG_RD_I && hit |=> CFG_RDATA_O[CFG_DATA_W-1:RSVD_LSB] == '0)
    else $error("reserved bits not zero");
  AST_PENDING:
    assert property (NP_ISSUE_I && !NP_DONE_I |=> CFG_RD_I && hit |=> CFG_RDATA_O[BIT_PENDING])
    else $error("pending bit low after issue");
  AST_AUX_SEEN:
    assert property (CFG_RD_I && hit && $past(AUX_DETECT_I) |=> CFG_RDATA_O[BIT_AUX_SEEN])
    else $error("aux detect not reported");
  AST_FATAL_FLAG:
    assert property (FATAL_DET_I |=> CFG_RD_I && hit |=> CFG_RDATA_O[FLAG_LSB + FLG_FATAL])
    else $error("fatal flag not set");
  AST_W1C:
    assert property (wr_hit && CFG_BE_I[2] && CFG_WDATA_I[FLAG_LSB + FLG_UNSUP] && !UNSUP_DET_I
                     |=> !flags.flag[FLG_UNSUP])
    else $error("unsupported flag not cleared");
  AST_ZERO_WRITE:
    assert property (wr_hit && CFG_BE_I[2] && !CFG_WDATA_I[FLAG_LSB + FLG_COR] && flags.flag[FLG_COR]
                     |=> flags.flag[FLG_COR])
    else $error("zero write cleared a flag");
  AST_HARDWIRED:
    assert property (CFG_RD_I |=> (CFG_RDATA_O[BIT_WIDE_TAG +: 2] == '0) && !CFG_RDATA_O[BIT_NO_SNOOP]
                     && !CFG_RDATA_O[BIT_RELAXED])
    else $error("hardwired field nonzero");
  AST_RETRY_STATUS:
    assert property (wr_hit && CFG_BE_I[1] && CFG_WDATA_I[BIT_RETRY] ##1 DS_CFG_REQ_I && DS_NOT_READY_I
                     |-> CONFIG_RETRY_STATUS_O)
    else $error("retry status missing");
  AST_RETRY_GATE:
    assert property (!retry_en_r |-> !CONFIG_RETRY_STATUS_O)
    else $error("retry status while disabled");
  AST_FATAL_MSG:
    assert property (FATAL_DET_I && fatal_report_r |=> MSG_FATAL_O)
    else $error("fatal message missing");
  AST_NONFATAL_GATE:
    assert property (!nonfatal_report_r && !SERR_ALLOW_I |=> !MSG_NONFATAL_O)
    else $error("non-fatal message while gated");
  AST_COR_GATE:
    assert property (MSG_COR_O |-> $past(COR_DET_I && correctable_report_r))
    else $error("correctable message without cause");
  AST_FLAG_UNGATED:
    assert property (COR_DET_I && !correctable_report_r |=> flags.flag[FLG_COR] && !MSG_COR_O)
    else $error("flag depends on enable");
  AST_READ_LIMIT:
    assert property (wr_hit && CFG_BE_I[1] && CFG_WDATA_I[MRRS_LSB +: 3] == 3'h5
                     |=> READ_LIMIT_BYTES_O == 13'h1000)
    else $error("read limit decode wrong");
  AST_PAYLOAD:
    assert property (wr_hit && CFG_BE_I[0] |=> (PAYLOAD_BYTES_O == BYTES_128)
                     && (csr_value[MPS_LSB +: 3] == $past(CFG_WDATA_I[MPS_LSB +: 3])))
    else $error("payload not 128 bytes or field not stored");
  AST_ACK_PULSE:
    assert property (CFG_RD_I || CFG_WR_I |=> CFG_ACK_O)
    else $error("access not acknowledged");
  AST_NP_DRAINED:
    assert property (np_cnt_r == 6'h01 && NP_DONE_I && !NP_ISSUE_I |=> !NP_PENDING_O)
    else $error("pending stays high after last completion");
  AST_AUX_USE:
    assert property (wr_hit && CFG_BE_I[1] |=> AUX_USE_ALLOW_O == $past(CFG_WDATA_I[BIT_AUX_USE]))
    else $error("aux use enable not applied");
  AST_UR_GATE:
    assert property (UNSUP_DET_I && !unsupported_req_report_r && !NONFATAL_DET_I |=> !MSG_NONFATAL_O)
    else $error("unsupported request reported while disabled");
  AST_NF_MSG:
    assert property (NONFATAL_DET_I && nonfatal_report_r |=> MSG_NONFATAL_O)
    else $error("non-fatal message missing");
  AST_COR_MSG:
    assert property (COR_DET_I && correctable_report_r |=> MSG_COR_O)
    else $error("correctable message missing");

  COV_CLEAR_RACE: cover property (wr_hit && CFG_BE_I[2] && CFG_WDATA_I[FLAG_LSB + FLG_FATAL] && FATAL_DET_I);
  COV_RETRY:      cover property (CONFIG_RETRY_STATUS_O);
  COV_NP_DRAIN:   cover property (nonposted_outstanding ##[1:20] !nonposted_outstanding);
  COV_UR_MSG:     cover property (UNSUP_DET_I && unsupported_req_report_r ##1 MSG_NONFATAL_O);
endmodule : dcs_device_ctl_status

// File: hdl/dcs_sticky_flags.sv
// bank of write-one-to-clear sticky flags
`timescale 1ns/10ps
module dcs_sticky_flags (
  // clock and reset
  input  wire logic     CLK_I,
  input  wire logic     RST_I,
  // flag carrier
  dcs_flag_if.owner     fl
);
  import dcs_pkg::*;

  logic [NUM_FLAGS-1:0] flag_r;
  logic [NUM_FLAGS-1:0] flag_nxt;

  // detection is applied after the clear so an event in the clearing cycle survives
  always_comb begin
    flag_nxt = (flag_r & ~fl.clear) | fl.detect;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign fl.flag = flag_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  AST_SET_WINS_CLEAR:
    assert property ((fl.detect & fl.clear) != '0 |=> (flag_r & $past(fl.detect & fl.clear)) == $past(fl.detect & fl.clear))
    else $error("flag lost when detect met clear");
  AST_FLAG_HOLDS:
    assert property (((flag_r & ~fl.clear) != '0) |=> ((flag_r & $past(flag_r & ~fl.clear)) == $past(flag_r & ~fl.clear)))
    else $error("sticky flag dropped without a clear");
endmodule : dcs_sticky_flags

// File: shared/dcs_flag_if.sv
// carrier between the register block and its sticky flag bank
`timescale 1ns/10ps
interface dcs_flag_if;
  import dcs_pkg::*;
  logic [NUM_FLAGS-1:0] detect;
  logic [NUM_FLAGS-1:0] clear;
  logic [NUM_FLAGS-1:0] flag;
  modport owner (input detect, input clear, output flag);
  modport user  (output detect, output clear, input flag);
endinterface : dcs_flag_if

// File: shared/dcs_pkg.sv
// constants and types for the device control and status word
package dcs_pkg;
  // register placement and reset image
  localparam logic [11:0] DCS_OFFSET       = 12'h0c8;
  localparam logic [31:0] DCS_RESET        = 32'h0000_2000;
  localparam int          CFG_ADDR_W       = 12;
  localparam int          CFG_DATA_W       = 32;
  localparam int          CFG_BE_W         = 4;

  // field positions
  localparam int          RSVD_LSB         = 22;
  localparam int          BIT_PENDING      = 21;
  localparam int          BIT_AUX_SEEN     = 20;
  localparam int          FLAG_LSB         = 16;
  localparam int          BIT_RETRY        = 15;
  localparam int          MRRS_LSB         = 12;
  localparam int          BIT_NO_SNOOP     = 11;
  localparam int          BIT_AUX_USE      = 10;
  localparam int          BIT_PHANTOM      = 9;
  localparam int          BIT_WIDE_TAG     = 8;
  localparam int          MPS_LSB          = 5;
  localparam int          BIT_RELAXED      = 4;
  localparam int          BIT_UR_REPORT    = 3;
  localparam int          BIT_FATAL_REPORT = 2;
  localparam int          BIT_NF_REPORT    = 1;
  localparam int          BIT_COR_REPORT   = 0;

  // sticky error flags, index i sits at FLAG_LSB + i
  localparam int          NUM_FLAGS        = 4;
  localparam int          FLG_COR          = 0;
  localparam int          FLG_NONFATAL     = 1;
  localparam int          FLG_FATAL        = 2;
  localparam int          FLG_UNSUP        = 3;

  typedef logic [2:0]  dcs_size_t;
  typedef logic [12:0] dcs_bytes_t;

  // field reset values
  localparam dcs_size_t   MRRS_RST         = 3'h2;
  localparam dcs_size_t   MPS_RST          = 3'h0;
  localparam logic        CTRL_BIT_RST     = 1'b0;

  // size decoding
  localparam dcs_size_t   MRRS_MAX_CODE    = 3'h5;
  localparam dcs_bytes_t  BYTES_128        = 13'h0080;
  localparam int          NP_CNT_W         = 6;

  // read request size code to bytes; reserved codes fall back to the smallest size
  function automatic dcs_bytes_t dcs_size_bytes(input dcs_size_t code);
    dcs_size_bytes = (code > MRRS_MAX_CODE) ? BYTES_128 : dcs_bytes_t'(BYTES_128 << code);
  endfunction : dcs_size_bytes
endpackage : dcs_pkg
